// file: design/nmd_defs.svh
`ifndef NMD_DEFS_SVH
`define NMD_DEFS_SVH

// Register offsets
`define NMD_OFS_STATUS     8'h86
`define NMD_OFS_LOW_LO     8'h87
`define NMD_OFS_LOW_HI     8'h88
`define NMD_OFS_UPPER_LO   8'h89
`define NMD_OFS_UPPER_HI   8'h8A
`define NMD_OFS_SRC2_LO    8'h8B
`define NMD_OFS_SRC2_HI    8'h8C
`define NMD_OFS_REM_LO     8'h8D
`define NMD_OFS_REM_HI     8'h8E
`define NMD_OFS_IRQ_STAT   8'h8F
`define NMD_OFS_IRQ_MASK   8'h90

// Status field positions
`define NMD_BIT_MUL_START  0
`define NMD_BIT_DIV_START  1
`define NMD_BIT_ZERO_DIV   2
`define NMD_BIT_OVERFLOW   3

// Interrupt status bits
`define NMD_IRQ_MUL_DONE   0
`define NMD_IRQ_DIV_DONE   1

// Reset values
`define NMD_RST_NIB        4'h0
`define NMD_RST_IRQ        2'h0

// Timing in machine cycles
`define NMD_MUL_CYCLES     5
`define NMD_DIV_CYCLES     10
`define NMD_CNT_W          4

// Divide-by-zero quotient
`define NMD_DIV0_QUOT      16'hFFFF
`define NMD_ZERO_BYTE      8'h00

`endif

// file: design/nmd_pkg.sv
package nmd_pkg;

    typedef enum logic [1:0] {
        NMD_IDLE = 2'b00,
        NMD_MUL  = 2'b01,
        NMD_DIV  = 2'b10
    } nmd_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [3:0] wdata;
        logic       wr;
        logic       rd;
    } nmd_bus_req_t;

    typedef struct packed {
        logic [15:0] quot;
        logic [7:0]  rem;
        logic        zero_div;
    } nmd_div_res_t;

endpackage : nmd_pkg

// file: design/nmd_divider.sv
`timescale 1ns/1ps
`include "nmd_defs.svh"

module nmd_divider
    import nmd_pkg::*;
(
    input  wire logic [15:0] dividend_i,
    input  wire logic [7:0]  divisor_i,
    output nmd_div_res_t     res_o
);
    logic [15:0] quot_w;
    logic [7:0]  rem_w;
    logic        zero_w;

    assign zero_w = (divisor_i == `NMD_ZERO_BYTE);
    assign quot_w = zero_w ? `NMD_DIV0_QUOT : (dividend_i / {8'h00, divisor_i});
    assign rem_w  = zero_w ? dividend_i[7:0]
                           : 8'(dividend_i % {8'h00, divisor_i});

    assign res_o.quot     = quot_w;
    assign res_o.rem      = rem_w;
    assign res_o.zero_div = zero_w;

endmodule : nmd_divider

// file: design/nmd_unit.sv
`timescale 1ns/1ps
`include "nmd_defs.svh"

// Overview of operation
// - Multiply low by second source; product high/low into upper/low pairs after 5 cycles.
// - Divide upper:low by second source; quotient back, remainder out, after 10 cycles.
// - After multiply, overflow flag set if upper pair nonzero, else cleared.
// - After divide, zero-divisor flag set if second source is zero, else cleared.
// - Divide by zero gives FFFF quotient and old low pair as remainder.
// - Writing one to multiply start begins; bit self-clears when product is ready.
// - Writing one to divide start begins unless multiply start is also set in the same write; bit self-clears when results written.
// - Reset clears start bits, flags and all nibble registers.
// - Each byte is two nibble registers, low address holds bits 3..0.

module nmd_unit
    import nmd_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [3:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [3:0] rdata_o,
    output logic            irq_o
);
    nmd_bus_req_t req;
    assign req.addr  = addr_i;
    assign req.wdata = wdata_i;
    assign req.wr    = wr_i;
    assign req.rd    = rd_i;

    nmd_state_t                 state_q;
    nmd_state_t                 state_d;
    logic [`NMD_CNT_W-1:0]      cnt_q;
    logic [`NMD_CNT_W-1:0]      cnt_d;
    logic [7:0]                 low_q;
    logic [7:0]                 low_d;
    logic [7:0]                 upper_q;
    logic [7:0]                 upper_d;
    logic [7:0]                 src2_q;
    logic [7:0]                 src2_d;
    logic [7:0]                 rem_q;
    logic [7:0]                 rem_d;
    logic                       ovf_q;
    logic                       ovf_d;
    logic                       zdiv_q;
    logic                       zdiv_d;
    logic [1:0]                 irq_stat_q;
    logic [1:0]                 irq_stat_d;
    logic [1:0]                 irq_mask_q;
    logic [1:0]                 irq_mask_d;
    logic [3:0]                 rdata_q;
    logic [3:0]                 rdata_d;

    // Address decode
    logic sel_stat, sel_ll, sel_lh, sel_ul, sel_uh, sel_sl, sel_sh, sel_rl, sel_rh;
    logic sel_is, sel_im;
    assign sel_stat = (req.addr == `NMD_OFS_STATUS);
    assign sel_ll   = (req.addr == `NMD_OFS_LOW_LO);
    assign sel_lh   = (req.addr == `NMD_OFS_LOW_HI);
    assign sel_ul   = (req.addr == `NMD_OFS_UPPER_LO);
    assign sel_uh   = (req.addr == `NMD_OFS_UPPER_HI);
    assign sel_sl   = (req.addr == `NMD_OFS_SRC2_LO);
    assign sel_sh   = (req.addr == `NMD_OFS_SRC2_HI);
    assign sel_rl   = (req.addr == `NMD_OFS_REM_LO);
    assign sel_rh   = (req.addr == `NMD_OFS_REM_HI);
    assign sel_is   = (req.addr == `NMD_OFS_IRQ_STAT);
    assign sel_im   = (req.addr == `NMD_OFS_IRQ_MASK);

    logic idle_w;
    logic start_mul_w;
    logic start_div_w;
    logic done_w;
    logic mul_done_w;
    logic div_done_w;
    assign idle_w      = (state_q == NMD_IDLE);
    assign start_mul_w = idle_w && req.wr && sel_stat
                         && req.wdata[`NMD_BIT_MUL_START];
    assign start_div_w = idle_w && req.wr && sel_stat && !start_mul_w
                         && req.wdata[`NMD_BIT_DIV_START];
    assign done_w      = !idle_w && (cnt_q == `NMD_CNT_W'(1));
    assign mul_done_w  = done_w && (state_q == NMD_MUL);
    assign div_done_w  = done_w && (state_q == NMD_DIV);

    // Arithmetic results
    logic [15:0]  prod_w;
    nmd_div_res_t div_w;
    assign prod_w = {8'h00, low_q} * {8'h00, src2_q};

    nmd_divider u_div (
        .dividend_i ({upper_q, low_q}),
        .divisor_i  (src2_q),
        .res_o      (div_w)
    );

    // Sequencer
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            NMD_IDLE: begin
                if (start_mul_w) begin
                    state_d = NMD_MUL;
                    cnt_d   = `NMD_CNT_W'(`NMD_MUL_CYCLES);
                end else if (start_div_w) begin
                    state_d = NMD_DIV;
                    cnt_d   = `NMD_CNT_W'(`NMD_DIV_CYCLES);
                end
            end
            NMD_MUL, NMD_DIV: begin
                cnt_d = cnt_q - `NMD_CNT_W'(1);
                if (done_w) begin
                    state_d = NMD_IDLE;
                end
            end
            default: begin
                state_d = NMD_IDLE;
            end
        endcase
    end

    // Operand and result registers
    always_comb begin
        low_d   = low_q;
        upper_d = upper_q;
        src2_d  = src2_q;
        rem_d   = rem_q;
        ovf_d   = ovf_q;
        zdiv_d  = zdiv_q;
        if (req.wr) begin
            if (sel_ll) begin
                low_d[3:0] = req.wdata;
            end else if (sel_lh) begin
                low_d[7:4] = req.wdata;
            end else if (sel_ul) begin
                upper_d[3:0] = req.wdata;
            end else if (sel_uh) begin
                upper_d[7:4] = req.wdata;
            end else if (sel_sl) begin
                src2_d[3:0] = req.wdata;
            end else if (sel_sh) begin
                src2_d[7:4] = req.wdata;
            end else if (sel_rl) begin
                rem_d[3:0] = req.wdata;
            end else if (sel_rh) begin
                rem_d[7:4] = req.wdata;
            end
        end
        if (mul_done_w) begin
            upper_d = prod_w[15:8];
            low_d   = prod_w[7:0];
            ovf_d   = (prod_w[15:8] != `NMD_ZERO_BYTE);
        end else if (div_done_w) begin
            upper_d = div_w.quot[15:8];
            low_d   = div_w.quot[7:0];
            rem_d   = div_w.rem;
            zdiv_d  = div_w.zero_div;
        end
    end

    // Interrupt status, set wins over clear
    always_comb begin
        irq_stat_d = irq_stat_q;
        irq_mask_d = irq_mask_q;
        if (req.wr && sel_is) begin
            irq_stat_d = irq_stat_q & ~req.wdata[1:0];
        end
        if (req.wr && sel_im) begin
            irq_mask_d = req.wdata[1:0];
        end
        if (mul_done_w) begin
            irq_stat_d[`NMD_IRQ_MUL_DONE] = 1'b1;
        end
        if (div_done_w) begin
            irq_stat_d[`NMD_IRQ_DIV_DONE] = 1'b1;
        end
    end

    // Read mux
    logic [3:0] stat_nib_w;
    assign stat_nib_w = {ovf_q, zdiv_q, state_q == NMD_DIV, state_q == NMD_MUL};

    always_comb begin
        rdata_d = 4'h0;
        if (req.rd) begin
            if (sel_stat) begin
                rdata_d = stat_nib_w;
            end else if (sel_ll) begin
                rdata_d = low_q[3:0];
            end else if (sel_lh) begin
                rdata_d = low_q[7:4];
            end else if (sel_ul) begin
                rdata_d = upper_q[3:0];
            end else if (sel_uh) begin
                rdata_d = upper_q[7:4];
            end else if (sel_sl) begin
                rdata_d = src2_q[3:0];
            end else if (sel_sh) begin
                rdata_d = src2_q[7:4];
            end else if (sel_rl) begin
                rdata_d = rem_q[3:0];
            end else if (sel_rh) begin
                rdata_d = rem_q[7:4];
            end else if (sel_is) begin
                rdata_d = {2'b00, irq_stat_q};
            end else if (sel_im) begin
                rdata_d = {2'b00, irq_mask_q};
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_q    <= NMD_IDLE;
            cnt_q      <= '0;
            low_q      <= {2{`NMD_RST_NIB}};
            upper_q    <= {2{`NMD_RST_NIB}};
            src2_q     <= {2{`NMD_RST_NIB}};
            rem_q      <= {2{`NMD_RST_NIB}};
            ovf_q      <= 1'b0;
            zdiv_q     <= 1'b0;
            irq_stat_q <= `NMD_RST_IRQ;
            irq_mask_q <= `NMD_RST_IRQ;
            rdata_q    <= 4'h0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            low_q      <= low_d;
            upper_q    <= upper_d;
            src2_q     <= src2_d;
            rem_q      <= rem_d;
            ovf_q      <= ovf_d;
            zdiv_q     <= zdiv_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            rdata_q    <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o   = |(irq_stat_q & irq_mask_q);

endmodule : nmd_unit

// file: test/nmd_unit_props.sv
`timescale 1ns/1ps
module nmd_unit_props (
    input wire logic       core_clk_i,
    input wire logic       sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [3:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [3:0] rdata_o,
    input wire logic       irq_o
);
    int         left_q;
    logic [1:0] mask_q;
    wire        st_rd = rd_i && addr_i == 8'h86;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            left_q <= 0;
            mask_q <= 2'h0;
        end else begin
            if (wr_i && addr_i == 8'h86 && |wdata_i[1:0] && left_q == 0) begin
                left_q <= wdata_i[0] ? 5 : 10;
            end else if (left_q != 0) begin
                left_q <= left_q - 1;
            end
            if (wr_i && addr_i == 8'h90) begin
                mask_q <= wdata_i[1:0];
            end
        end
    end
    property p_echo;
        wr_i && addr_i inside {[8'h87:8'h8E]} && left_q == 0 ##1 !wr_i
            ##1 rd_i && addr_i == $past(addr_i, 2) |=> rdata_o == $past(wdata_i, 3);
    endproperty
    a_rdata_idle: assert property (!rd_i |=> rdata_o == 4'h0)
        else $error("read data not idle");
    a_unmapped_zero: assert property (rd_i && (addr_i < 8'h86 || addr_i > 8'h90) |=> rdata_o == 4'h0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property ($fell(sys_rst_i) |-> rdata_o == 4'h0 && !irq_o)
        else $error("outputs not clear after reset");
    a_nib_echo: assert property (p_echo)
        else $error("nibble readback differs");
    a_busy_reads: assert property (st_rd && left_q > 0 |=> rdata_o[1:0] != 2'h0)
        else $error("start bits clear while running");
    a_idle_reads: assert property (st_rd && left_q == 0 |=> rdata_o[1:0] == 2'h0)
        else $error("start bits set while idle");
    a_irq_mask: assert property (irq_o |-> mask_q != 2'h0)
        else $error("interrupt with all sources masked");
    a_mask_off: assert property (wr_i && addr_i == 8'h90 && wdata_i[1:0] == 2'h0 |=> !irq_o)
        else $error("interrupt stays after masking");
    c_mul: cover property (wr_i && addr_i == 8'h86 && wdata_i[0] && left_q == 0);
    c_div: cover property (wr_i && addr_i == 8'h86 && wdata_i == 4'h2 && left_q == 0);
    c_irq: cover property ($rose(irq_o));
endmodule : nmd_unit_props

bind nmd_unit nmd_unit_props i_nmd_unit_props (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o)
);

// file: test/tb_nmd_unit.sv
`timescale 1ns/1ps
module tb_nmd_unit;
    logic       core_clk_i;
    logic       sys_rst_i;
    logic [7:0] addr_i;
    logic [3:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic [3:0] rdata_o;
    logic       irq_o;
    logic [3:0] rv;
    logic [7:0] rem_q;
    logic [1:0] last_fl;
    int         bad_count;
    int         checks_done;
    nmd_unit i_nmd_unit (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o)
    );
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(posedge core_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
    endtask : rd
    task automatic wr8(input logic [7:0] a, input logic [7:0] v);
        wr(a, v[3:0]);
        wr(a + 8'h01, v[7:4]);
    endtask : wr8
    task automatic rd8(input logic [7:0] a, output logic [7:0] v);
        rd(a);
        v[3:0] = rv;
        rd(a + 8'h01);
        v[7:4] = rv;
    endtask : rd8
    task automatic t_reset;
        for (int a = 8'h86; a <= 8'h91; a++) begin
            rd(8'(a));
            chk(rv, 4'h0);
        end
        chk(irq_o, 1'b0);
        wr(8'h91, 4'hF);
        wr(8'h86, 4'hC);
        rd(8'h91);
        chk(rv, 4'h0);
        rd(8'h86);
        chk(rv, 4'h0);
        wr(8'h8B, 4'hA);
        rd(8'h8B);
        chk(rv, 4'hA);
    endtask : t_reset
    task automatic run_op(input logic [7:0] lo, up, src, input logic [3:0] go);
        logic [15:0] p;
        logic [15:0] r;
        logic [23:0] e;
        logic [23:0] g;
        logic [1:0]  fl;
        fl = last_fl;
        if (go[0]) begin
            p = lo * src;
            fl[1] = p[15:8] != 8'h00;
            e = {p, rem_q};
        end else if (src == 8'h00) begin
            fl[0] = 1'b1;
            e = {16'hFFFF, lo};
        end else begin
            p = {up, lo} / src;
            r = {up, lo} % src;
            fl[0] = 1'b0;
            e = {p, r[7:0]};
        end
        wr8(8'h87, lo);
        wr8(8'h89, up);
        wr8(8'h8B, src);
        wr(8'h86, go);
        wr(8'h86, 4'h3);
        repeat (go[0] ? 1 : 6) @(posedge core_clk_i);
        rd(8'h86);
        chk(rv, {last_fl, !go[0], go[0]});
        rd(8'h86);
        chk(rv, {fl, 2'b00});
        rd8(8'h89, g[23:16]);
        rd8(8'h87, g[15:8]);
        rd8(8'h8D, g[7:0]);
        chk(g, e);
        rd(8'h8F);
        chk(rv, {2'b00, !go[0], go[0]});
        wr(8'h8F, 4'h3);
        last_fl = fl;
        rem_q = e[7:0];
    endtask : run_op
    task automatic t_irq;
        wr(8'h90, 4'h2);
        wr(8'h86, 4'h2);
        repeat (8) @(posedge core_clk_i);
        wr(8'h8F, 4'h2);
        #1 chk(irq_o, 1'b1);
        wr(8'h90, 4'h1);
        #1 chk(irq_o, 1'b0);
        wr(8'h90, 4'h2);
        #1 chk(irq_o, 1'b1);
        wr(8'h8F, 4'h2);
        #1 chk(irq_o, 1'b0);
    endtask : t_irq
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end
    initial begin
        sys_rst_i   = 1'b1;
        addr_i      = 8'h00;
        wdata_i     = 4'h0;
        wr_i        = 1'b0;
        rd_i        = 1'b0;
        rem_q       = 8'h00;
        last_fl     = 2'h0;
        bad_count   = 0;
        checks_done = 0;
        repeat (12) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        run_op(8'hF3, 8'h00, 8'hE7, 4'h1);
        run_op(8'h0B, 8'h55, 8'h0C, 4'h3);
        run_op(8'h34, 8'h12, 8'h56, 4'h2);
        run_op(8'h34, 8'h12, 8'h00, 4'h2);
        run_op(8'hFF, 8'hFF, 8'h01, 4'h2);
        t_irq();
        wrap_up();
    end
endmodule : tb_nmd_unit
